// file: verilog/mwe_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "mwe_map.svh"

module mwe_port #(
  parameter int PROG_CYCLES = `MWE_PROG_TIME_NS / `MWE_CLK_PERIOD_NS
) (
  // clock, reset, enable
  input  wire logic clock_in,
  input  wire logic reset_in,
  input  wire logic ce_in,
  // serial bus pins
  input  wire logic cs_in,
  input  wire logic sk_in,
  input  wire logic di_in,
  output var  logic do_out,
  output var  logic do_oe_out,
  // status
  output var  logic busy_out,
  output var  logic write_en_out
);
  // ----------------------------------------------------------------
  // pin synchronisers: cs, sk, di
  // ----------------------------------------------------------------
  logic [2:0] pin_m_q;
  logic [2:0] pin_s_q;
  logic       sk_prev_q;
  logic       cs_prev_q;
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      pin_m_q   <= 3'h0;
      pin_s_q   <= 3'h0;
      sk_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end else if (ce_in) begin
      pin_m_q   <= {cs_in, sk_in, di_in};
      pin_s_q   <= pin_m_q;
      sk_prev_q <= pin_s_q[1];
      cs_prev_q <= pin_s_q[2];
    end
  end

  logic cs;
  logic di;
  logic sk_rise;
  logic cs_fall;
  assign cs      = pin_s_q[2];
  assign di      = pin_s_q[0];
  assign sk_rise = pin_s_q[1] & ~sk_prev_q & cs;
  assign cs_fall = cs_prev_q & ~cs;

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  mwe_pkg::mwe_state_t state_q;
  logic [4:0]          cnt_q;
  logic [23:0]         sr_q;
  logic [23:0]         sh;
  logic [1:0]          op;
  logic [1:0]          sub;
  logic                busy_q;
  logic                status_q;
  logic                wen_q;
  logic                wall_q;
  logic                read_start;
  logic                arm_fall;
  logic                prog_done;
  logic [18:0]         prog_cnt_q;
  mwe_pkg::mwe_addr_t  waddr_q;

  assign sh  = {sr_q[22:0], di};
  assign op  = sh[`MWE_OP_MSB -: 2];
  assign sub = sh[`MWE_SUB_MSB -: 2];
  assign read_start = sk_rise && state_q == mwe_pkg::MWE_CMD &&
                      cnt_q == `MWE_CNT_ADDR_LAST && op == `MWE_OP_READ;
  assign arm_fall   = cs_fall && state_q == mwe_pkg::MWE_ARMED && wen_q;
  assign prog_done  = busy_q && prog_cnt_q == 19'h0_0001;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= mwe_pkg::MWE_IDLE;
      cnt_q   <= 5'h00;
      sr_q    <= 24'h00_0000;
      waddr_q <= '0;
      wall_q  <= 1'b0;
    end else if (ce_in) begin
      if (!cs) begin
        state_q <= mwe_pkg::MWE_IDLE;
      end else if (sk_rise) begin
        unique case (state_q)
          mwe_pkg::MWE_IDLE: begin
            // busy refuses new commands; zeros before the start bit fall away
            if (di && !busy_q) begin
              state_q <= mwe_pkg::MWE_CMD;
              cnt_q   <= 5'h01;
              sr_q    <= 24'h00_0000;
            end
          end
          mwe_pkg::MWE_CMD: begin
            sr_q  <= sh;
            cnt_q <= 5'(cnt_q + 1'b1);
            if (cnt_q == `MWE_CNT_ADDR_LAST) begin
              waddr_q <= sh[`MWE_ADDR_MSB:0];
              wall_q  <= (op == `MWE_OP_SPECIAL);
              if (op == `MWE_OP_READ) begin
                state_q <= mwe_pkg::MWE_READ;
              end else if (op == `MWE_OP_WRITE ||
                           (op == `MWE_OP_SPECIAL && sub == `MWE_SUB_WALL)) begin
                state_q <= mwe_pkg::MWE_DATA;
              end else begin
                state_q <= mwe_pkg::MWE_DONE;
              end
            end
          end
          mwe_pkg::MWE_DATA: begin
            sr_q  <= sh;
            cnt_q <= 5'(cnt_q + 1'b1);
            if (cnt_q == `MWE_CNT_DATA_LAST) state_q <= mwe_pkg::MWE_ARMED;
          end
          // a 26th clock before deselect cancels the write
          mwe_pkg::MWE_ARMED: state_q <= mwe_pkg::MWE_DONE;
          mwe_pkg::MWE_READ:  state_q <= mwe_pkg::MWE_READ;
          mwe_pkg::MWE_DONE:  state_q <= mwe_pkg::MWE_DONE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // write enable latch
  // ----------------------------------------------------------------
  logic special_decode;
  assign special_decode = sk_rise && state_q == mwe_pkg::MWE_CMD &&
                          cnt_q == `MWE_CNT_ADDR_LAST && op == `MWE_OP_SPECIAL;
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      wen_q <= `MWE_WEN_RESET;
    end else if (ce_in && special_decode) begin
      if (sub == `MWE_SUB_WEN) wen_q <= 1'b1;
      if (sub == `MWE_SUB_WDS) wen_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // self-timed programming
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      busy_q     <= 1'b0;
      prog_cnt_q <= 19'h0_0000;
      status_q   <= 1'b0;
    end else if (ce_in) begin
      if (arm_fall) begin
        busy_q     <= 1'b1;
        prog_cnt_q <= 19'(PROG_CYCLES);
        status_q   <= 1'b1;
      end else if (busy_q) begin
        prog_cnt_q <= 19'(prog_cnt_q - 1'b1);
        if (prog_done) busy_q <= 1'b0;
      end
      if (sk_rise && state_q == mwe_pkg::MWE_IDLE && di && !busy_q) begin
        status_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // word array, flip-flops; the new word replaces the old in one step,
  // which covers the erase before program
  // ----------------------------------------------------------------
  mwe_pkg::mwe_word_t mem_q [64];
  mwe_pkg::mwe_word_t wdata_q;
  always_ff @(posedge clock_in) begin
    if (ce_in && state_q == mwe_pkg::MWE_DATA && sk_rise &&
        cnt_q == `MWE_CNT_DATA_LAST) begin
      wdata_q <= sh[15:0];
    end
  end
  for (genvar i = 0; i < 64; i++) begin : g_word
    always_ff @(posedge clock_in) begin
      if (ce_in && prog_done && (wall_q || waddr_q == 6'(i))) begin
        mem_q[i] <= wdata_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // read prefetch into the fifo, address wraps at the top
  // ----------------------------------------------------------------
  mwe_fifo_if         fq ();
  mwe_pkg::mwe_addr_t fetch_q;
  logic               fetch_on_q;
  logic [3:0]         rbit_q;
  mwe_pkg::mwe_word_t oshift_q;
  logic               pop;

  assign pop         = sk_rise && state_q == mwe_pkg::MWE_READ && rbit_q == 4'h0;
  assign fq.flush    = !cs || read_start;
  assign fq.in_valid = fetch_on_q;
  assign fq.in_data  = mem_q[fetch_q];
  assign fq.out_ready = pop;

  mwe_fifo #(
    .WIDTH (16),
    .DEPTH (`MWE_FIFO_DEPTH)
  ) u_fifo (
    .clk_in   (clock_in),
    .reset_in (reset_in),
    .ce_in    (ce_in),
    .f        (fq)
  );

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      fetch_q    <= '0;
      fetch_on_q <= 1'b0;
    end else if (ce_in) begin
      if (read_start) begin
        fetch_q    <= sh[`MWE_ADDR_MSB:0];
        fetch_on_q <= 1'b1;
      end else if (!cs) begin
        fetch_on_q <= 1'b0;
      end else if (fetch_on_q && fq.in_ready) begin
        fetch_q <= 6'(fetch_q + 1'b1);
      end
    end
  end

  // ----------------------------------------------------------------
  // data output; a word is held in the fifo long before its first bit
  // is due, since a serial clock period spans many system clocks
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      do_out    <= 1'b1;
      do_oe_out <= 1'b0;
      rbit_q    <= 4'h0;
      oshift_q  <= 16'h0000;
    end else if (ce_in) begin
      do_oe_out <= cs && (state_q == mwe_pkg::MWE_READ || status_q);
      if (read_start) begin
        do_out <= 1'b0;
        rbit_q <= 4'h0;
      end else if (sk_rise && state_q == mwe_pkg::MWE_READ) begin
        rbit_q <= 4'(rbit_q + 1'b1);
        if (rbit_q == 4'h0) begin
          do_out   <= fq.out_data[15];
          oshift_q <= {fq.out_data[14:0], 1'b0};
        end else begin
          do_out   <= oshift_q[15];
          oshift_q <= {oshift_q[14:0], 1'b0};
        end
      end else if (state_q != mwe_pkg::MWE_READ) begin
        do_out <= ~busy_q;
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      busy_out     <= 1'b0;
      write_en_out <= 1'b0;
    end else if (ce_in) begin
      busy_out     <= busy_q;
      write_en_out <= wen_q;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_armed_fall;
    ce_in && arm_fall;
  endsequence
  sequence s_read_decode;
    ce_in && read_start;
  endsequence

  property p_float_deselected;
    ce_in && !cs |=> !do_oe_out;
  endproperty
  a_float_deselected: assert property (p_float_deselected)
    else $error("data output enabled while deselected");

  property p_start_bit;
    ce_in && sk_rise && state_q == mwe_pkg::MWE_IDLE && di && !busy_q
      |=> state_q == mwe_pkg::MWE_CMD && cnt_q == 5'h01;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("start bit not taken");

  property p_zero_ignored;
    ce_in && cs && sk_rise && state_q == mwe_pkg::MWE_IDLE && !di
      |=> state_q == mwe_pkg::MWE_IDLE;
  endproperty
  a_zero_ignored: assert property (p_zero_ignored)
    else $error("leading zero left idle");

  property p_dummy_zero;
    s_read_decode ##1 ce_in && cs |=> !do_out && do_oe_out;
  endproperty
  a_dummy_zero: assert property (p_dummy_zero)
    else $error("no dummy zero after read address");

  property p_wen;
    ce_in && special_decode && sub == `MWE_SUB_WEN |=> wen_q;
  endproperty
  a_wen: assert property (p_wen)
    else $error("write enable not set");

  property p_wds;
    ce_in && special_decode && sub == `MWE_SUB_WDS |=> !wen_q;
  endproperty
  a_wds: assert property (p_wds)
    else $error("write disable not applied");

  property p_prog_start;
    s_armed_fall |=> busy_q && status_q && prog_cnt_q == 19'(PROG_CYCLES);
  endproperty
  a_prog_start: assert property (p_prog_start)
    else $error("programming did not start");

  property p_late_cancel;
    ce_in && sk_rise && state_q == mwe_pkg::MWE_ARMED
      |=> state_q == mwe_pkg::MWE_DONE ##1 !busy_q;
  endproperty
  a_late_cancel: assert property (p_late_cancel)
    else $error("26th clock did not cancel write");

  property p_busy_low;
    busy_q && $past(busy_q, 2) && do_oe_out |-> !do_out;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("busy not shown low");

  property p_no_write_disabled;
    ce_in && cs_fall && state_q == mwe_pkg::MWE_ARMED && !wen_q && !busy_q
      |=> !busy_q;
  endproperty
  a_no_write_disabled: assert property (p_no_write_disabled)
    else $error("write started while disabled");
endmodule // mwe_port

`default_nettype wire

// file: verilog/mwe_map.svh
`ifndef MWE_MAP_SVH
`define MWE_MAP_SVH

// ----------------------------------------------------------------
// command fields
// ----------------------------------------------------------------
`define MWE_OP_READ      2'b10
`define MWE_OP_WRITE     2'b01
`define MWE_OP_SPECIAL   2'b00
`define MWE_SUB_WEN      2'b11
`define MWE_SUB_WALL     2'b01
`define MWE_SUB_WDS      2'b00
`define MWE_OP_MSB       7
`define MWE_SUB_MSB      5
`define MWE_ADDR_MSB     5

// ----------------------------------------------------------------
// clock counts within a command, start bit is clock 1
// ----------------------------------------------------------------
`define MWE_CNT_ADDR_LAST 5'h08
`define MWE_CNT_DATA_LAST 5'h18

// ----------------------------------------------------------------
// timing and reset values
// ----------------------------------------------------------------
`define MWE_CLK_PERIOD_NS 10
`define MWE_PROG_TIME_NS  4000000
`define MWE_WEN_RESET     1'b0
`define MWE_FIFO_DEPTH    8

`endif

// file: verilog/mwe_pkg.sv
package mwe_pkg;

  typedef logic [15:0] mwe_word_t;
  typedef logic [5:0]  mwe_addr_t;

  typedef enum logic [2:0] {
    MWE_IDLE,
    MWE_CMD,
    MWE_DATA,
    MWE_ARMED,
    MWE_READ,
    MWE_DONE
  } mwe_state_t;

endpackage

// file: verilog/mwe_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mwe_fifo_if;
  logic              flush;
  logic              in_valid;
  logic              in_ready;
  mwe_pkg::mwe_word_t in_data;
  logic              out_valid;
  logic              out_ready;
  mwe_pkg::mwe_word_t out_data;

  modport fifo (input flush, in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport user (output flush, in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface

`default_nettype wire

// file: verilog/mwe_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module mwe_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic ce_in,
  // data path
  mwe_fifo_if.fifo  f
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign f.in_ready  = (cnt_q != DEPTH[AW:0]);
  assign f.out_valid = (cnt_q != '0);
  assign f.out_data  = mem_q[rd_q];
  assign push = f.in_valid & f.in_ready;
  assign pop  = f.out_ready & f.out_valid;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (ce_in && push && !f.flush) begin
      mem_q[wr_q] <= f.in_data;
    end
  end

  // ----------------------------------------------------------------
  // pointers, flush wins over both sides
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce_in) begin
      if (f.flush) begin
        wr_q  <= '0;
        rd_q  <= '0;
        cnt_q <= '0;
      end else begin
        if (push) wr_q <= AW'(wr_q + 1'b1);
        if (pop)  rd_q <= AW'(rd_q + 1'b1);
        cnt_q <= (AW+1)'(cnt_q + push - pop);
      end
    end
  end
endmodule // mwe_fifo

`default_nettype wire

// file: verif/mwe_master.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// bus master model: sk period alternates 12 and 13 clocks (125 ns)
// ----------------------------------------------------------------
module mwe_master (
  // system clock
  input  wire logic clock_in,
  // serial bus pins
  output var  logic cs_out,
  output var  logic sk_out,
  output var  logic di_out,
  input  wire logic do_in,
  input  wire logic do_oe_in
);
  logic odd_q;

  initial begin
    cs_out = 1'b0;
    sk_out = 1'b0;
    di_out = 1'b1;
    odd_q  = 1'b0;
  end

  // di moves only while sk is low, so it is held well around each rise
  task automatic xfer(input logic d, output logic q);
    @(posedge clock_in);
    di_out <= d;
    repeat (odd_q ? 5 : 4) @(posedge clock_in);
    odd_q = ~odd_q;
    sk_out <= 1'b1;
    repeat (6) @(posedge clock_in);
    @(negedge clock_in);
    q = do_oe_in ? do_in : 1'bx;
    @(posedge clock_in);
    sk_out <= 1'b0;
  endtask

  // raise cs, then wait six clocks so the status is on the output before the first clock
  task automatic select;
    @(posedge clock_in);
    cs_out <= 1'b1;
    di_out <= 1'b0;
    repeat (6) @(posedge clock_in);
    @(negedge clock_in);
  endtask

  // released data line shows the inverse of its last level
  task automatic deselect;
    @(posedge clock_in);
    cs_out <= 1'b0;
    di_out <= ~di_out;
    repeat (22) @(posedge clock_in);
    @(negedge clock_in);
  endtask

  task automatic cmd(input logic [8:0] c, output logic q);
    for (int i = 8; i >= 0; i--) xfer(c[i], q);
  endtask

  task automatic word(input logic [15:0] d, output logic [15:0] q);
    for (int i = 15; i >= 0; i--) xfer(d[i], q[i]);
  endtask
endmodule // mwe_master

`default_nettype wire

// file: verif/microwire_eeprom_command_port_test.sv
`timescale 1ns/1ps
`default_nettype none

module microwire_eeprom_command_port_test;
  localparam int PROG = 200;
  localparam logic [8:0] C_WEN  = 9'h130;
  localparam logic [8:0] C_WDS  = 9'h100;
  localparam logic [8:0] C_WRITE_ALL_CMD = 9'h110;

  logic        clock_in;
  logic        reset_in;
  logic        ce_in;
  logic        cs_pin;
  logic        sk_pin;
  logic        di_pin;
  logic        do_pin;
  logic        do_oe;
  logic        busy;
  logic        wen;
  logic        q;
  logic [15:0] w;
  int          mismatches;
  int          checked;

  mwe_port #(.PROG_CYCLES(PROG)) u_dut (
    .clock_in    (clock_in),
    .reset_in    (reset_in),
    .ce_in       (ce_in),
    .cs_in       (cs_pin),
    .sk_in       (sk_pin),
    .di_in       (di_pin),
    .do_out      (do_pin),
    .do_oe_out   (do_oe),
    .busy_out    (busy),
    .write_en_out(wen)
  );

  mwe_master u_master (
    .clock_in(clock_in),
    .cs_out  (cs_pin),
    .sk_out  (sk_pin),
    .di_out  (di_pin),
    .do_in   (do_pin),
    .do_oe_in(do_oe)
  );

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // whole write-type command; an extra clock after the last data bit aborts it
  task automatic prog(input logic [8:0] c, input logic [15:0] d, input logic late);
    u_master.select();
    u_master.cmd(c, q);
    u_master.word(d, w);
    if (late) u_master.xfer(1'b0, q);
    u_master.deselect();
  endtask

  task automatic special(input logic [8:0] c);
    u_master.select();
    u_master.cmd(c, q);
    u_master.deselect();
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < PROG + 50) begin
      @(negedge clock_in);
      n++;
    end
    check("busy end", 16'h0000, {15'h0000, busy});
  endtask

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power;
    check("write enable", 16'h0000, {15'h0000, wen});
    check("busy", 16'h0000, {15'h0000, busy});
    check("output enable", 16'h0000, {15'h0000, do_oe});
    $display("test power done");
  endtask

  task automatic t_unlock;
    prog({3'b101, 6'h05}, 16'hdead, 1'b0);
    check("locked busy", 16'h0000, {15'h0000, busy});
    u_master.select();
    for (int i = 0; i < 3; i++) u_master.xfer(1'b0, q);
    u_master.cmd(C_WEN, q);
    u_master.deselect();
    check("write enable", 16'h0001, {15'h0000, wen});
    $display("test unlock done");
  endtask

  task automatic t_write_all_cmd;
    prog(C_WRITE_ALL_CMD, 16'ha5c3, 1'b0);
    check("busy start", 16'h0001, {15'h0000, busy});
    u_master.select();
    check("status busy", 16'h0002, {14'h0000, do_oe, do_pin});
    u_master.cmd(C_WDS, q);
    u_master.deselect();
    check("refused command", 16'h0001, {15'h0000, wen});
    wait_ready();
    u_master.select();
    check("status ready", 16'h0003, {14'h0000, do_oe, do_pin});
    u_master.deselect();
    check("released output", 16'h0000, {15'h0000, do_oe});
    $display("test write all done");
  endtask

  task automatic t_write;
    prog({3'b101, 6'h3f}, 16'h1234, 1'b0);
    check("write busy", 16'h0001, {15'h0000, busy});
    wait_ready();
    // frozen enable: a reselect must not reach the output until enable returns
    @(posedge clock_in);
    ce_in <= 1'b0;
    u_master.select();
    check("frozen enable", 16'h0000, {15'h0000, do_oe});
    @(posedge clock_in);
    ce_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    @(negedge clock_in);
    check("status after enable", 16'h0003, {14'h0000, do_oe, do_pin});
    u_master.deselect();
    prog({3'b101, 6'h00}, 16'h0f0f, 1'b1);
    check("late deselect", 16'h0000, {15'h0000, busy});
    $display("test write done");
  endtask

  task automatic t_read;
    special(C_WDS);
    check("write disable", 16'h0000, {15'h0000, wen});
    u_master.select();
    u_master.cmd({3'b110, 6'h3e}, q);
    check("dummy bit", 16'h0000, {15'h0000, q});
    u_master.word(16'h0000, w);
    check("word 3e", 16'ha5c3, w);
    u_master.word(16'h0000, w);
    check("word 3f", 16'h1234, w);
    u_master.word(16'h0000, w);
    check("word 00", 16'ha5c3, w);
    u_master.deselect();
    check("released output", 16'h0000, {15'h0000, do_oe});
    $display("test read done");
  endtask

  initial begin
    #500_000;
    mismatches++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    reset_in   = 1'b1;
    ce_in      = 1'b1;
    mismatches = 0;
    checked    = 0;
    repeat (3) @(posedge clock_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
    t_power();
    t_unlock();
    t_write_all_cmd();
    t_write();
    t_read();
    wrap_up();
  end
endmodule // microwire_eeprom_command_port_test

`default_nettype wire
